// [pkg/lane_pkg.sv]
// Purpose: Shared constants, types and decode functions for the little-endian lane steering bridge.
// Assumes: 32-bit internal data bus, 24-bit external address, external width 8, 16 or 32 bits.
// Notes: Sizes and widths are carried as log2 of their byte count, which keeps the lane arithmetic small.
package lane_pkg;

    // Bus widths.
    localparam int DATA_W = 32;
    localparam int CORE_ADDR_W = 32;
    localparam int EXT_ADDR_W = 24;

    // Bank width strap codes.
    localparam logic [1:0] WCODE_8 = 2'h1;
    localparam logic [1:0] WCODE_16 = 2'h2;
    localparam logic [1:0] WCODE_32 = 2'h3;

    // Access size codes on the core request port.
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;

    // Log2 of a byte count.
    localparam logic [1:0] LOG_1 = 2'h0;
    localparam logic [1:0] LOG_2 = 2'h1;
    localparam logic [1:0] LOG_4 = 2'h2;

    // Bank 0 width assumed until the strap has settled.
    localparam logic [1:0] STRAP_RESET = WCODE_32;

    // Controller states.
    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_issue = 2'b01,
        st_wait = 2'b10,
        st_resp = 2'b11
    } state_t;

    // Byte lane mask for a unit of 2**lg bytes placed at lane 0.
    function automatic logic [3:0] lane_mask(input logic [1:0] lg);
        case (lg)
            LOG_1: lane_mask = 4'h1;
            LOG_2: lane_mask = 4'h3;
            default: lane_mask = 4'hf;
        endcase
    endfunction

    // Expands a byte lane mask to a bit mask.
    function automatic logic [31:0] bit_mask(input logic [3:0] m);
        bit_mask = {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
    endfunction

    // Strap code to log2 of the width in bytes; the unused code falls back to 32 bits.
    function automatic logic [1:0] width_log(input logic [1:0] code);
        case (code)
            WCODE_8: width_log = LOG_1;
            WCODE_16: width_log = LOG_2;
            default: width_log = LOG_4;
        endcase
    endfunction

    // Access size code to log2 of bytes; the unused code is taken as a word.
    function automatic logic [1:0] size_log(input logic [1:0] code);
        case (code)
            SIZE_BYTE: size_log = LOG_1;
            SIZE_HALF: size_log = LOG_2;
            default: size_log = LOG_4;
        endcase
    endfunction

    // Replicates the low unit of the given size across all four lanes.
    function automatic logic [31:0] replicate(input logic [1:0] lg, input logic [31:0] d);
        case (lg)
            LOG_1: replicate = {4{d[7:0]}};
            LOG_2: replicate = {2{d[15:0]}};
            default: replicate = d;
        endcase
    endfunction

endpackage

// [src/lane_beat_map.sv]
// Purpose: Per-beat lane map: beat count, address offset, byte offset and byte enables of one beat.
// Assumes: Size and width are log2 byte counts; the request address is aligned to its size.
// Notes: Purely combinational; the parent registers everything it drives out.
`timescale 1ns/1ps
`default_nettype none
module lane_beat_map
    import lane_pkg::*;
(
    // Access shape.
    input wire logic [1:0] width_lg,
    input wire logic [1:0] size_lg,
    input wire logic [1:0] addr_lo,
    input wire logic [1:0] beat,
    // Beat map.
    output logic [1:0] beats_m1,
    output logic [1:0] ea_off,
    output logic [1:0] boff,
    output logic [3:0] wbe,
    output logic narrow
);

    // The access is wider than the bus and splits into several beats.
    wire is_narrow = size_lg > width_lg;
    // Log2 of the beat count when split.
    wire [1:0] diff = size_lg - width_lg;
    // Lane mask of half the beat count gives beats minus one in its low bits.
    wire [3:0] cnt_mask = lane_mask(diff - 2'h1);
    wire [1:0] last = is_narrow ? cnt_mask[1:0] : 2'h0;
    // Beats run from the highest chunk down to the base.
    wire [1:0] chunk = last - beat;
    // Chunk position in the word, in bytes.
    wire [3:0] chunk_pos = {2'h0, chunk} << width_lg;
    // Offset masks inside the external width and inside the access size.
    wire [3:0] wm = lane_mask(width_lg) >> 1;
    wire [3:0] sm = lane_mask(size_lg) >> 1;
    // Lane of a unit narrower than the bus, chosen by the low address bits.
    wire [1:0] lane = addr_lo & wm[1:0] & ~sm[1:0];
    wire [1:0] off = is_narrow ? chunk_pos[1:0] : lane;
    // Only lanes that carry the unit are enabled.
    wire [3:0] en = is_narrow ? lane_mask(width_lg) : lane_mask(size_lg) << off;

    assign beats_m1 = last;
    assign ea_off = chunk;
    assign boff = off;
    assign wbe = en;
    assign narrow = is_narrow;

endmodule
`default_nettype wire

// [src/little_endian_lane_steering.sv]
// Purpose: Steers core loads and stores onto an 8, 16 or 32-bit little-endian external memory bus.
// Assumes: Core requests are aligned to their size; an external timing block acknowledges each beat.
// Notes: One request is in flight at a time; bank 0 width comes from a strap, other banks from an input.
//
// Overview of operation
// - 32-bit bus: word in one beat, order kept.
// - 32-bit bus: halfword replicated, address picks half.
// - 32-bit bus: byte lane chosen by address bits.
// - 32-bit bus: narrow loads pick lane, replicate.
// - 16-bit bus: word store, upper half first.
// - 16-bit bus: word load, upper half first.
// - 16-bit bus: halfword low lanes, byte by parity.
// - 8-bit bus: word store, four beats, MSB first.
// - 8-bit bus: loads gather bytes into word.
// - 8-bit bus: halfword two beats, upper first.
// - Bank 0 width taken from strap pins.
// - External address is 24 bits wide.
`timescale 1ns/1ps
`default_nettype none
module little_endian_lane_steering
    import lane_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Bank 0 width strap pins.
    input wire logic [1:0] bank0_width_strap,
    // Core request.
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [1:0] req_size,
    input wire logic [lane_pkg::CORE_ADDR_W-1:0] req_addr,
    input wire logic [lane_pkg::DATA_W-1:0] req_wdata,
    input wire logic [2:0] req_bank,
    input wire logic [1:0] req_bank_width,
    output logic req_ready,
    // Core response.
    output logic rsp_valid,
    output logic [lane_pkg::DATA_W-1:0] rsp_rdata,
    // External memory beat port.
    output logic ext_req,
    output logic ext_write,
    output logic [lane_pkg::EXT_ADDR_W-1:0] external_beat_address,
    output logic [lane_pkg::DATA_W-1:0] ext_wdata,
    output logic [3:0] ext_wbe,
    input wire logic ext_ack,
    input wire logic [lane_pkg::DATA_W-1:0] ext_rdata
);

    // Strap synchroniser stages and the settled bank 0 width code.
    logic [1:0] strap_s1_ff;
    logic [1:0] strap_s2_ff;
    logic [1:0] strap_s3_ff;
    logic [1:0] bank0_width_ff;

    // Controller state and beat counter.
    state_t state_ff;
    logic [1:0] beat_ff;

    // Latched request.
    logic [1:0] wlog_ff;
    logic [1:0] slog_ff;
    logic write_ff;
    logic [CORE_ADDR_W-1:0] addr_ff;
    logic [DATA_W-1:0] wdata_ff;
    logic [DATA_W-1:0] acc_ff;

    // Output registers.
    logic req_ready_ff;
    logic rsp_valid_ff;
    logic [DATA_W-1:0] rsp_rdata_ff;
    logic ext_req_ff;
    logic ext_write_ff;
    logic [EXT_ADDR_W-1:0] ext_addr_ff;
    logic [DATA_W-1:0] ext_wdata_ff;
    logic [3:0] ext_wbe_ff;

    // Beat map for the current beat.
    logic [1:0] beats_m1;
    logic [1:0] ea_off;
    logic [1:0] boff;
    logic [3:0] wbe;
    logic narrow;

    // A request is taken when the core offers one and the bridge is free.
    wire take = req_valid && req_ready_ff;
    // The last beat of the access is acknowledged.
    wire last_ack = ext_ack && (beat_ff == beats_m1);
    // Width of the addressed bank: strap for bank 0, configuration otherwise.
    wire [1:0] sel_code = (req_bank == 3'h0) ? bank0_width_ff : req_bank_width;
    wire [1:0] req_slog = size_log(req_size);
    // Core data bus as the core drives it: narrow stores replicated on all lanes.
    wire [DATA_W-1:0] bus_wdata = replicate(req_slog, req_wdata);
    // Base beat address counts in units of the external width.
    wire [CORE_ADDR_W-1:0] unit_addr = addr_ff >> wlog_ff;
    wire [EXT_ADDR_W-1:0] base_ea = unit_addr[EXT_ADDR_W-1:0];
    wire [EXT_ADDR_W-1:0] beat_ea = base_ea + {{(EXT_ADDR_W-2){1'b0}}, ea_off};
    // Byte offset expressed as a bit shift.
    wire [4:0] bit_shift = {boff, 3'h0};
    // Store data of this beat: the chunk or lane moved onto the external lanes.
    wire [DATA_W-1:0] beat_wdata = narrow ? (wdata_ff >> bit_shift) : wdata_ff;
    // Lanes the external bus really has, used to clear don't-care read lanes.
    wire [DATA_W-1:0] bus_keep = bit_mask(lane_mask(wlog_ff));
    // Read gathering: split loads place each chunk at its word position.
    wire [DATA_W-1:0] gathered = acc_ff | ((ext_rdata & bus_keep) << bit_shift);
    // Single-beat loads pick the addressed lane down to lane 0.
    wire [DATA_W-1:0] picked = ext_rdata >> bit_shift;
    wire [DATA_W-1:0] nxt_acc = narrow ? gathered : picked;
    // Response data is replicated across the core bus for narrow sizes.
    wire [DATA_W-1:0] nxt_rsp = replicate(slog_ff, nxt_acc);

    // Lane map for the beat being issued.
    lane_beat_map u_map (
        .width_lg(wlog_ff),
        .size_lg(slog_ff),
        .addr_lo(addr_ff[1:0]),
        .beat(beat_ff),
        .beats_m1(beats_m1),
        .ea_off(ea_off),
        .boff(boff),
        .wbe(wbe),
        .narrow(narrow)
    );

    // Three-stage strap synchroniser; the code counts once the last two stages agree.
    always_ff @(posedge clk) begin
        if (rst) begin
            strap_s1_ff <= STRAP_RESET;
            strap_s2_ff <= STRAP_RESET;
            strap_s3_ff <= STRAP_RESET;
            bank0_width_ff <= STRAP_RESET;
        end else begin
            strap_s1_ff <= bank0_width_strap;
            strap_s2_ff <= strap_s1_ff;
            strap_s3_ff <= strap_s2_ff;
            // Only a stable code replaces the held width.
            if (strap_s2_ff == strap_s3_ff) begin
                bank0_width_ff <= strap_s3_ff;
            end
        end
    end

    // Request latch: shape and data are frozen for the whole access.
    always_ff @(posedge clk) begin
        if (rst) begin
            wlog_ff <= LOG_4;
            slog_ff <= LOG_4;
            write_ff <= 1'b0;
            addr_ff <= '0;
            wdata_ff <= '0;
        end else if (take) begin
            wlog_ff <= width_log(sel_code);
            slog_ff <= req_slog;
            write_ff <= req_write;
            addr_ff <= req_addr;
            wdata_ff <= bus_wdata;
        end
    end

    // Load accumulator: cleared on a new request, updated on every acknowledged beat.
    always_ff @(posedge clk) begin
        if (rst) begin
            acc_ff <= '0;
        end else if (take) begin
            acc_ff <= '0;
        end else if (state_ff == st_wait && ext_ack) begin
            acc_ff <= nxt_acc;
        end
    end

    // External beat registers, loaded on the same edge that raises ext_req to offer the beat.
    always_ff @(posedge clk) begin
        if (rst) begin
            ext_write_ff <= 1'b0;
            ext_addr_ff <= '0;
            ext_wdata_ff <= '0;
            ext_wbe_ff <= 4'h0;
        end else if (state_ff == st_issue) begin
            ext_write_ff <= write_ff;
            ext_addr_ff <= beat_ea;
            ext_wdata_ff <= beat_wdata;
            // Loads enable no byte lane for writing.
            ext_wbe_ff <= write_ff ? wbe : 4'h0;
        end else if (state_ff == st_wait && ext_ack) begin
            // Enables drop with the beat so no lane stays marked between beats.
            ext_wbe_ff <= 4'h0;
        end
    end

    // Controller: take, issue each beat, wait for its acknowledge, answer.
    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= st_idle;
            beat_ff <= 2'h0;
            req_ready_ff <= 1'b0;
            rsp_valid_ff <= 1'b0;
            rsp_rdata_ff <= '0;
            ext_req_ff <= 1'b0;
        end else begin
            case (state_ff)
                // Free: accept the next core request.
                st_idle: begin
                    req_ready_ff <= 1'b1;
                    if (take) begin
                        req_ready_ff <= 1'b0;
                        beat_ff <= 2'h0;
                        state_ff <= st_issue;
                    end
                end
                // Offer the beat as its registers are loaded on the same edge.
                st_issue: begin
                    ext_req_ff <= 1'b1;
                    state_ff <= st_wait;
                end
                // Hold the beat until the memory side acknowledges it.
                st_wait: begin
                    if (last_ack) begin
                        ext_req_ff <= 1'b0;
                        rsp_valid_ff <= 1'b1;
                        rsp_rdata_ff <= nxt_rsp;
                        state_ff <= st_resp;
                    end else if (ext_ack) begin
                        // More chunks remain; step to the next lower address.
                        ext_req_ff <= 1'b0;
                        beat_ff <= beat_ff + 2'h1;
                        state_ff <= st_issue;
                    end
                end
                // One-cycle response, then free again.
                st_resp: begin
                    rsp_valid_ff <= 1'b0;
                    req_ready_ff <= 1'b1;
                    state_ff <= st_idle;
                end
                default: begin
                    state_ff <= st_idle;
                end
            endcase
        end
    end

    // Every output comes straight from a register.
    assign req_ready = req_ready_ff;
    assign rsp_valid = rsp_valid_ff;
    assign rsp_rdata = rsp_rdata_ff;
    assign ext_req = ext_req_ff;
    assign ext_write = ext_write_ff;
    assign external_beat_address = ext_addr_ff;
    assign ext_wdata = ext_wdata_ff;
    assign ext_wbe = ext_wbe_ff;

endmodule
`default_nettype wire

// [dv/lane_steering_sva.sv]
// Purpose: Port checker for the lane steering bridge.
// Assumes: Sees only the ports of the top module.
// Notes: Attached by the bind after the module.
`timescale 1ns/1ps
`default_nettype none
module lane_steering_sva
    import lane_pkg::*;
(
    // Clock, reset and core side.
    input wire logic clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [1:0] req_size,
    input wire logic [lane_pkg::CORE_ADDR_W-1:0] req_addr,
    input wire logic [lane_pkg::DATA_W-1:0] req_wdata,
    input wire logic [2:0] req_bank,
    input wire logic [1:0] req_bank_width,
    input wire logic req_ready,
    input wire logic rsp_valid,
    // Beat side.
    input wire logic ext_req,
    input wire logic ext_write,
    input wire logic [lane_pkg::EXT_ADDR_W-1:0] external_beat_address,
    input wire logic [lane_pkg::DATA_W-1:0] ext_wdata,
    input wire logic [3:0] ext_wbe,
    input wire logic ext_ack
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // A store taken on a non-zero bank of width w and size s.
    sequence st_take(w, s);
        req_valid && req_ready && req_write && req_bank != 3'h0 && req_bank_width == w && req_size == s;
    endsequence
    // The first beat shows two edges after the take.
    sequence first_beat;
        ##2 ext_req;
    endsequence
    AST_READ_NO_WBE: assert property (ext_req && !ext_write |-> ext_wbe == 4'h0)
        else $error("byte enables on a read beat");
    AST_BEAT_HOLD: assert property (ext_req && !ext_ack |=> ext_req && $stable(ext_wdata) && $stable(ext_wbe)
        && $stable(external_beat_address)) else $error("beat changed before ack");
    AST_BEAT_DROP: assert property (ext_req && ext_ack |=> !ext_req && ext_wbe == 4'h0)
        else $error("beat not dropped after ack");
    AST_RSP_PULSE: assert property (rsp_valid |=> !rsp_valid) else $error("response longer than one cycle");
    AST_BUSY: assert property (ext_req |-> !req_ready) else $error("ready during a beat");
    AST_W32_WORD: assert property (st_take(WCODE_32, SIZE_WORD) |-> first_beat ##0 (ext_wbe == 4'hf
        && ext_wdata == $past(req_wdata, 2) && external_beat_address == $past(req_addr[25:2], 2)))
        else $error("word beat wrong on 32-bit bus");
    AST_B32_LANE: assert property (st_take(WCODE_32, SIZE_BYTE) |-> first_beat ##0
        ext_wbe == 4'h1 << $past(req_addr[1:0], 2)) else $error("byte lane wrong on 32-bit bus");
    AST_H16_LANE: assert property (st_take(WCODE_16, SIZE_HALF) |-> first_beat ##0 ext_wbe == 4'h3)
        else $error("half lanes wrong on 16-bit bus");
    AST_W8_FIRST: assert property (st_take(WCODE_8, SIZE_WORD) |-> first_beat ##0 (ext_wbe == 4'h1
        && ext_wdata[7:0] == $past(req_wdata[31:24], 2)
        && external_beat_address == $past(req_addr[23:0], 2) + 24'h3)) else $error("first byte beat wrong");
endmodule
bind little_endian_lane_steering lane_steering_sva u_lane_steering_sva (.clk(clk), .rst(rst),
    .req_valid(req_valid), .req_write(req_write), .req_size(req_size), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_bank(req_bank), .req_bank_width(req_bank_width), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .ext_req(ext_req), .ext_write(ext_write), .ext_wdata(ext_wdata),
    .external_beat_address(external_beat_address), .ext_wbe(ext_wbe), .ext_ack(ext_ack));
`default_nettype wire

// [dv/ext_mem_model.sv]
// Purpose: Behavioural static memory on the beat port.
// Assumes: One word per beat address.
// Notes: Data outside an ack is inverted so a stale value never passes.
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model
    import lane_pkg::*;
(
    // Clock and ack delay.
    input wire logic clk,
    input wire logic [2:0] dly,
    // Beat port.
    input wire logic ext_req,
    input wire logic ext_write,
    input wire logic [lane_pkg::EXT_ADDR_W-1:0] external_beat_address,
    input wire logic [lane_pkg::DATA_W-1:0] ext_wdata,
    input wire logic [3:0] ext_wbe,
    output logic ext_ack,
    output logic [lane_pkg::DATA_W-1:0] ext_rdata
);
    logic [31:0] mem [0:255];
    logic [2:0] wait_ff = 3'h0;
    logic [31:0] word;
    // Fill with a known pattern so unwritten lanes are never unknown.
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 32'h5a5a0000 | i;
        end
    end
    assign word = mem[external_beat_address[7:0]];
    // Ack after dly cycles of a standing beat.
    assign ext_ack = ext_req && (wait_ff >= dly);
    assign ext_rdata = ext_ack ? word : ~word;
    // Only lanes with an enable are written.
    always @(posedge clk) begin
        wait_ff <= (ext_req && !ext_ack) ? wait_ff + 3'h1 : 3'h0;
        for (int b = 0; b < 4; b++) begin
            if (ext_ack && ext_write && ext_wbe[b]) begin
                mem[external_beat_address[7:0]][8*b +: 8] <= ext_wdata[8*b +: 8];
            end
        end
    end
endmodule
`default_nettype wire

// [dv/little_endian_lane_steering_tb.sv]
// Purpose: Self-checking bench for the lane steering bridge.
// Assumes: Memory model acks each beat.
// Notes: Rows run twice, with prompt and slow acks.
`timescale 1ns/1ps
`default_nettype none
module little_endian_lane_steering_tb;
    import lane_pkg::*;
    typedef struct packed {logic wr; logic [1:0] sz; logic [7:0] a; logic [31:0] d; logic [2:0] bk;
        logic [1:0] wc;} row_t;
    logic clk = 1'b0, rst = 1'b1, req_valid = 1'b0, req_write = 1'b0, req_ready, rsp_valid;
    logic ext_req, ext_write, ext_ack;
    logic [1:0] strap = 2'h3, req_size = 2'h0, req_bank_width = 2'h3;
    logic [2:0] req_bank = 3'h0, dly = 3'h0;
    logic [31:0] req_addr = 32'h0, req_wdata = 32'h0, rsp_rdata, ext_wdata, ext_rdata;
    logic [23:0] external_beat_address;
    logic [3:0] ext_wbe;
    logic [7:0] sh [0:255];
    logic [59:0] beats [$];
    int n_fail = 0, num_checks = 0;
    row_t rows [25] = '{'{1,2,8'h00,32'h44332211,1,3}, '{1,1,8'h06,32'hbbaa,1,3}, '{1,0,8'h05,32'hcc,1,3},
        '{1,0,8'h03,32'hdd,1,3}, '{0,2,8'h00,0,1,3}, '{0,1,8'h06,0,1,3}, '{0,1,8'h00,0,1,3}, '{0,0,8'h05,0,1,3},
        '{0,0,8'h03,0,1,3}, '{1,2,8'h40,32'h88776655,2,2}, '{1,1,8'h46,32'h2211,2,2}, '{1,0,8'h45,32'h33,2,2},
        '{1,0,8'h44,32'h44,2,2}, '{0,2,8'h40,0,2,2}, '{0,2,8'h44,0,2,2}, '{0,0,8'h45,0,2,2}, '{0,1,8'h42,0,2,2},
        '{1,2,8'h80,32'hddccbbaa,0,1}, '{1,1,8'h86,32'h1234,0,1}, '{1,0,8'h85,32'hee,0,1}, '{0,2,8'h80,0,0,1},
        '{0,1,8'h86,0,0,1}, '{0,0,8'h85,0,0,1}, '{1,2,8'hc0,32'h0badcafe,0,2}, '{0,2,8'hc0,0,0,2}};
    little_endian_lane_steering u_little_endian_lane_steering (.clk(clk), .rst(rst),
        .bank0_width_strap(strap), .req_valid(req_valid), .req_write(req_write), .req_size(req_size),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_bank(req_bank), .req_bank_width(req_bank_width),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .ext_req(ext_req),
        .ext_write(ext_write), .external_beat_address(external_beat_address), .ext_wdata(ext_wdata),
        .ext_wbe(ext_wbe), .ext_ack(ext_ack), .ext_rdata(ext_rdata));
    ext_mem_model u_ext_mem_model (.clk(clk), .dly(dly), .ext_req(ext_req), .ext_write(ext_write),
        .external_beat_address(external_beat_address), .ext_wdata(ext_wdata), .ext_wbe(ext_wbe),
        .ext_ack(ext_ack), .ext_rdata(ext_rdata));
    // The 40 MHz clock.
    initial begin
        forever #12.5 clk = ~clk;
    end
    // Each acked beat is recorded with its written lanes only.
    always @(posedge clk) begin
        if (ext_req && ext_ack) begin
            beats.push_back({external_beat_address, ext_wbe, ext_wdata & {{8{ext_wbe[3]}}, {8{ext_wbe[2]}},
                {8{ext_wbe[1]}}, {8{ext_wbe[0]}}}});
        end
    end
    task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk1(input string nm, input logic e, input logic g);
        chk32(nm, {31'h0, e}, {31'h0, g});
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Presents one request and holds it until taken.
    task automatic start_req(input row_t r);
        int t;
        t = 0;
        beats.delete();
        @(posedge clk);
        #1 {req_write, req_size, req_addr, req_wdata, req_bank, req_bank_width} = {r.wr, r.sz, 24'h0, r.a,
            r.d, r.bk, r.wc};
        req_valid = 1'b1;
        @(negedge clk);
        while (req_ready !== 1'b1 && t < 50) begin
            @(negedge clk);
            t++;
        end
        @(posedge clk);
        #1 req_valid = 1'b0;
    endtask
    // Runs a row and checks every beat and the load result.
    task automatic run_row(input row_t r);
        int wb, sb, n, lg, off, ln, t;
        logic [31:0] e;
        wb = (r.wc == 2'h1) ? 1 : (r.wc == 2'h2) ? 2 : 4;
        sb = (r.sz == 2'h0) ? 1 : (r.sz == 2'h1) ? 2 : 4;
        lg = (wb == 1) ? 0 : (wb == 2) ? 1 : 2;
        n = (sb > wb) ? sb / wb : 1;
        ln = (sb < wb) ? r.a % wb : 0;
        t = 0;
        if (r.bk == 3'h0) begin
            @(posedge clk);
            #1 strap = r.wc;
            repeat (6) @(posedge clk);
        end
        start_req(r);
        while (rsp_valid !== 1'b1 && t < 100) begin
            @(negedge clk);
            t++;
        end
        chk1("rsp_valid", 1'b1, rsp_valid);
        chk32("beats", n, beats.size());
        for (int k = 0; k < n && k < beats.size(); k++) begin
            off = (n - 1 - k) * wb;
            chk32("addr", (r.a + off) >> lg, {8'h0, beats[k][59:36]});
            e = 32'(r.wr ? (((r.d >> (off * 8)) & ((64'h1 << (8 * (sb < wb ? sb : wb))) - 1)) << (8 * ln)) : 0);
            chk32("data", e, beats[k][31:0]);
            e = r.wr ? ((1 << (sb < wb ? sb : wb)) - 1) << ln : 0;
            chk32("wbe", e, {28'h0, beats[k][35:32]});
        end
        for (int i = 0; i < 4; i++) begin
            if (r.wr && i < sb) sh[r.a + i] = r.d[8*i +: 8];
            e[8*i +: 8] = sh[r.a + (i % sb)];
        end
        if (!r.wr) chk32("rdata", e, rsp_rdata);
    endtask
    // Watchdog cuts a hang short.
    initial begin
        #500000;
        n_fail++;
        $display("[ERR] watchdog expected done seen hang");
        complete_run();
    end
    // Reset, both row passes, then a reset while the first beat of a split store stands.
    initial begin
        repeat (3) @(posedge clk);
        #1 chk1("ready_rst", 1'b0, req_ready);
        chk1("req_rst", 1'b0, ext_req);
        rst = 1'b0;
        for (int p = 0; p < 2; p++) begin
            dly = 3'(3 * p);
            foreach (rows[i]) run_row(rows[i]);
        end
        // Slow acks keep the first byte beat waiting when reset arrives.
        start_req('{1, 2, 8'h80, 32'h01020304, 1, 1});
        repeat (3) @(posedge clk);
        #1 chk1("req_mid", 1'b1, ext_req);
        chk32("addr_mid", 32'h83, {8'h0, external_beat_address});
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #1 chk1("req_abort", 1'b0, ext_req);
        chk1("rsp_abort", 1'b0, rsp_valid);
        chk1("ready_abort", 1'b0, req_ready);
        rst = 1'b0;
        run_row(rows[0]);
        run_row(rows[4]);
        complete_run();
    end
endmodule
`default_nettype wire
